// ### logic/clk_ctrl.sv
// main/sub oscillator control and cpu bus clock selection
// assumes oscillator clocks arrive as pins slower than clk/4
//
// Function
// - after reset the main oscillator runs and the sub oscillator stays off.
// - after reset the bus clock is the main clock divided by 8.
// - main halt bit 5 of control 0 stops the main oscillator, zero runs it outside stop mode.
// - the divider is forced to 8 while main halt or stop mode is set.
// - main drive bit 5 of control 1 resets to one, set on stop from main-speed modes.
// - sub enable bit 4 starts the sub oscillator, select bit 7 moves the bus clock to it.
// - sub drive bit 3 of control 0 resets to one and is set on stop entry.
// - bus clock is the sub clock or main divided by 1,2,3,4,6,8,10,12,14,16.
// - the timer count clock is the sub clock divided by 32.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module clk_ctrl
    import clk_ctrl_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // oscillator pins
    input wire logic main_clk_pin,
    input wire logic sub_clk_pin,
    input wire logic wake_pin,
    output logic main_osc_run,
    output logic main_drive_high,
    output logic sub_osc_out,
    output logic sub_drive_high,
    // derived clocks
    output logic bus_clk,
    output logic bus_clk_sub,
    output logic sub_clock_direct,
    output logic sub_clock_div32
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic main_s1, main_s2, main_s3;
    logic sub_s1, sub_s2, sub_s3;
    logic wake_s1, wake_s2;

    always_ff @(posedge clk) begin
        main_s1 <= main_clk_pin;
        main_s2 <= main_s1;
        main_s3 <= main_s2;
        sub_s1 <= sub_clk_pin;
        sub_s2 <= sub_s1;
        sub_s3 <= sub_s2;
        wake_s1 <= wake_pin;
        wake_s2 <= wake_s1;
    end

    wire main_rise = main_s2 & ~main_s3;
    wire sub_rise = sub_s2 & ~sub_s3;
    wire sub_fall = ~sub_s2 & sub_s3;

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r, wdata_r;
    logic wlane_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;

    assign s_axi_awready = ~aw_full_r & ~bvalid_r;
    assign s_axi_wready = ~w_full_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    wire wr_go = aw_full_r & w_full_r & ~bvalid_r;
    wire wr_ctl0 = wr_go & wlane_r & (awaddr_r == ADDR_CTL0);
    wire wr_ctl1 = wr_go & wlane_r & (awaddr_r == ADDR_CTL1);
    wire wr_div = wr_go & wlane_r & (awaddr_r == ADDR_DIV);
    wire wr_hit = (awaddr_r == ADDR_CTL0) | (awaddr_r == ADDR_CTL1)
        | (awaddr_r == ADDR_DIV) | (awaddr_r == ADDR_STAT);
    wire rd_go = s_axi_arvalid & ~rvalid_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 8'h00;
            wlane_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_full_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r <= s_axi_wdata[7:0];
                wlane_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r & s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    ctl0_type ctl0_r, ctl0_nxt;
    ctl1_type ctl1_r, ctl1_nxt;
    logic [7:0] div_r, div_nxt;

    wire ctl0_type wr0 = ctl0_type'(wdata_r);
    wire ctl1_type wr1 = ctl1_type'(wdata_r);
    wire stop_entry = wr_ctl1 & wr1.stop & ~ctl1_r.stop;
    wire div_legal = (wdata_r == 8'h01) | (wdata_r == 8'h02) | (wdata_r == 8'h03)
        | (wdata_r == 8'h04) | (wdata_r == 8'h06) | (wdata_r == 8'h08)
        | (wdata_r == 8'h0a) | (wdata_r == 8'h0c) | (wdata_r == 8'h0e)
        | (wdata_r == 8'h10);

    always_comb begin
        ctl0_nxt = wr_ctl0 ? wr0 : ctl0_r;
        if (stop_entry) begin
            ctl0_nxt.sub_drv = 1'b1;
        end
        ctl1_nxt = wr_ctl1 ? wr1 : ctl1_r;
        // leaving stop only by wake, so a stray write cannot wake the part
        if (ctl1_r.stop) begin
            ctl1_nxt.stop = ~wake_s2;
        end
        if (stop_entry & ~ctl0_r.sys_sel) begin
            ctl1_nxt.main_drv = 1'b1;
        end
        // illegal ratios are dropped, keeping the old divider
        div_nxt = (wr_div & div_legal) ? wdata_r : div_r;
        if (ctl0_nxt.main_halt | ctl1_nxt.stop) begin
            div_nxt = DIV_BY8;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl0_r <= ctl0_type'(CTL0_RST);
            ctl1_r <= ctl1_type'(CTL1_RST);
            div_r <= DIV_BY8;
        end else begin
            ctl0_r <= ctl0_nxt;
            ctl1_r <= ctl1_nxt;
            div_r <= div_nxt;
        end
    end

    // ----------------------------------------
    // oscillator controls
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            main_osc_run <= 1'b1;
            sub_osc_out <= 1'b0;
            main_drive_high <= 1'b1;
            sub_drive_high <= 1'b1;
        end else begin
            main_osc_run <= ~ctl0_r.main_halt & ~ctl1_r.stop;
            sub_osc_out <= ctl0_r.sub_en & ~ctl1_r.stop;
            main_drive_high <= ctl1_r.main_drv;
            sub_drive_high <= ctl0_r.sub_drv;
        end
    end

    // ----------------------------------------
    // bus clock generation
    // ----------------------------------------
    src_type src_r;
    logic [7:0] cur_div_r, cnt_r;
    logic bclk_r;
    logic main_seen_r, sub_seen_r;

    wire [7:0] half = 8'((cur_div_r + 8'h01) >> 1);
    wire [7:0] cnt_inc = 8'(cnt_r + 8'h01);
    wire [7:0] cnt_nxt = (cnt_r >= cur_div_r - 8'h01) ? 8'h00 : cnt_inc;
    wire main_wrap = main_rise & (cnt_r >= cur_div_r - 8'h01);

    // changes land at a main period boundary while the output is low, except the switch back from sub, which lands on a sub clock fall
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_r <= SRC_MAIN;
            cur_div_r <= DIV_BY8;
            cnt_r <= 8'h00;
            bclk_r <= 1'b0;
        end else begin
            case (src_r)
                SRC_MAIN: begin
                    if (main_wrap & ctl0_r.sys_sel) begin
                        src_r <= SRC_SUB;
                        bclk_r <= 1'b0;
                        cnt_r <= 8'h00;
                    end else if (main_wrap) begin
                        cur_div_r <= div_r;
                        cnt_r <= 8'h00;
                        bclk_r <= 1'b1;
                    end else if (cur_div_r == 8'h01) begin
                        bclk_r <= main_s2;
                    end else if (main_rise) begin
                        cnt_r <= cnt_nxt;
                        bclk_r <= (cnt_nxt < half);
                    end
                end
                SRC_SUB: begin
                    // a dead sub clock freezes the bus clock at its last level here
                    if (sub_fall & ~ctl0_r.sys_sel) begin
                        src_r <= SRC_MAIN;
                        cur_div_r <= div_r;
                        cnt_r <= div_r - 8'h01;
                        bclk_r <= 1'b0;
                    end else if (sub_rise | sub_fall) begin
                        bclk_r <= sub_s2;
                    end
                end
                default: begin
                    src_r <= SRC_MAIN;
                end
            endcase
        end
    end

    assign bus_clk = bclk_r;
    assign bus_clk_sub = (src_r == SRC_SUB);

    // ----------------------------------------
    // sub clock outputs
    // ----------------------------------------
    logic [SUB_DIV_W-1:0] sub_cnt_r;
    logic sub_direct_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sub_cnt_r <= '0;
            sub_direct_r <= 1'b0;
            main_seen_r <= 1'b0;
            sub_seen_r <= 1'b0;
        end else begin
            sub_direct_r <= sub_s2;
            if (sub_rise) begin
                sub_cnt_r <= SUB_DIV_W'(sub_cnt_r + 1'b1);
            end
            main_seen_r <= main_rise | (main_seen_r & ~main_wrap);
            sub_seen_r <= sub_rise | (sub_seen_r & ~sub_fall);
        end
    end

    assign sub_clock_direct = sub_direct_r;
    assign sub_clock_div32 = sub_cnt_r[SUB_DIV_W-1];

    // ----------------------------------------
    // read path
    // ----------------------------------------
    stat_type stat;
    logic [7:0] rd_byte;

    always_comb begin
        stat = '0;
        stat.cur_sub = (src_r == SRC_SUB);
        stat.bus_clk = bclk_r;
        stat.sub_seen = sub_seen_r;
        stat.main_seen = main_seen_r;
        case (s_axi_araddr)
            ADDR_CTL0: rd_byte = ctl0_r;
            ADDR_CTL1: rd_byte = ctl1_r;
            ADDR_DIV: rd_byte = div_r;
            ADDR_STAT: rd_byte = stat;
            default: rd_byte = 8'h00;
        endcase
    end

    wire rd_hit = (s_axi_araddr == ADDR_CTL0) | (s_axi_araddr == ADDR_CTL1)
        | (s_axi_araddr == ADDR_DIV) | (s_axi_araddr == ADDR_STAT);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule

// ### logic/clk_ctrl_pkg.sv
// constants and carrier types for the main/sub clock control block
// assumes a 32-bit axi4-lite master and a 20 mhz system clock
package clk_ctrl_pkg;

    // ----------------------------------------
    // register indexes and byte addresses
    // ----------------------------------------
    localparam logic [7:0] IDX_CTL0 = 8'h06;
    localparam logic [7:0] IDX_CTL1 = 8'h07;
    localparam logic [7:0] IDX_DIV = 8'h0c;
    localparam logic [7:0] IDX_STAT = 8'h10;
    localparam logic [7:0] ADDR_CTL0 = {IDX_CTL0[5:0], 2'b00};
    localparam logic [7:0] ADDR_CTL1 = {IDX_CTL1[5:0], 2'b00};
    localparam logic [7:0] ADDR_DIV = {IDX_DIV[5:0], 2'b00};
    localparam logic [7:0] ADDR_STAT = {IDX_STAT[5:0], 2'b00};

    // ----------------------------------------
    // reset values and encodings
    // ----------------------------------------
    localparam logic [7:0] CTL0_RST = 8'h08;
    localparam logic [7:0] CTL1_RST = 8'h20;
    localparam logic [7:0] DIV_BY8 = 8'h08;
    localparam int SUB_DIV_W = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // register layouts
    // ----------------------------------------
    typedef struct packed {
        logic sys_sel;
        logic spare6;
        logic main_halt;
        logic sub_en;
        logic sub_drv;
        logic [2:0] spare;
    } ctl0_type;

    typedef struct packed {
        logic [1:0] spare_hi;
        logic main_drv;
        logic [3:0] spare_lo;
        logic stop;
    } ctl1_type;

    typedef struct packed {
        logic [3:0] spare;
        logic cur_sub;
        logic bus_clk;
        logic sub_seen;
        logic main_seen;
    } stat_type;

    typedef enum logic [0:0] {
        SRC_MAIN,
        SRC_SUB
    } src_type;

endpackage

// ### verification/clk_ctrl_sva.sv
// concurrent checks on the clock control block ports
// assumes write address and data are offered together
`timescale 1ns/10ps
module clk_ctrl_sva
    import clk_ctrl_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // oscillator and clock outputs
    input wire logic main_osc_run,
    input wire logic main_drive_high,
    input wire logic sub_osc_out,
    input wire logic sub_drive_high,
    input wire logic bus_clk,
    input wire logic bus_clk_sub
);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    endsequence
    sequence wr_ctl0;
        wr_take ##0 (s_axi_awaddr == ADDR_CTL0);
    endsequence
    sequence wr_ctl1;
        wr_take ##0 (s_axi_awaddr == ADDR_CTL1);
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    reset_state_a: assert property ($fell(sys_rst) |-> main_osc_run && !sub_osc_out
        && !bus_clk_sub) else $error("reset oscillator state wrong");
    reset_drive_a: assert property ($fell(sys_rst) |-> main_drive_high && sub_drive_high)
        else $error("reset drive state wrong");
    halt_stops_a: assert property (wr_ctl0 ##0 s_axi_wdata[5] |-> ##[1:3] !main_osc_run)
        else $error("main oscillator not halted");
    sub_start_a: assert property (wr_ctl0 ##0 (s_axi_wdata[5:4] == 2'b01 && main_osc_run)
        |-> ##[1:3] sub_osc_out) else $error("sub oscillator not started");
    stop_drive_a: assert property (wr_ctl1 ##0 (s_axi_wdata[0] && main_osc_run)
        |-> ##[1:3] (sub_drive_high && !main_osc_run)) else $error("stop entry wrong");
    clk_high_a: assert property ($rose(bus_clk) |=> bus_clk)
        else $error("bus clock high pulse cut");
    clk_low_a: assert property ($fell(bus_clk) |=> !bus_clk)
        else $error("bus clock low pulse cut");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    unmapped_err_a: assert property (wr_take ##0 (s_axi_awaddr == 8'h04) |-> ##2
        (s_axi_bvalid && s_axi_bresp == RESP_SLVERR)) else $error("unmapped write not refused");
endmodule

bind clk_ctrl clk_ctrl_sva chk (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .main_osc_run(main_osc_run), .main_drive_high(main_drive_high),
    .sub_osc_out(sub_osc_out), .sub_drive_high(sub_drive_high), .bus_clk(bus_clk),
    .bus_clk_sub(bus_clk_sub));

// ### verification/tb_top.sv
// self-checking bench for the clock control block
// assumes oscillator pins toggle only while enabled
`timescale 1ns/10ps
module tb_top
    import clk_ctrl_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, mp = 0, sp = 0, wk = 0;
    logic awr, wrd, bv, arr, rv, mrun, mdrv, sosc, sdrv, bclk, bsub, sdir, s32;
    logic [1:0] br, rr;
    logic [31:0] rdat;
    logic [7:0] dv [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10};
    int n_errors = 0, num_checks = 0;
    time t0;
    always #25 clk = ~clk;
    // oscillators stand still while disabled
    initial begin #13; forever #200 mp = mrun ? ~mp : 1'b0; end
    initial begin #37; forever #500 sp = sosc ? ~sp : 1'b0; end
    clk_ctrl dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .main_clk_pin(mp),
        .sub_clk_pin(sp), .wake_pin(wk), .main_osc_run(mrun), .main_drive_high(mdrv),
        .sub_osc_out(sosc), .sub_drive_high(sdrv), .bus_clk(bclk), .bus_clk_sub(bsub),
        .sub_clock_direct(sdir), .sub_clock_div32(s32));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
        logic ah, wh;
        logic [1:0] r;
        ah = 1'b0;
        wh = 1'b0;
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(negedge clk);
            if (awv && awr) ah = 1'b1;
            if (wv && wrd) wh = 1'b1;
            @(posedge clk);
            awv <= !ah;
            wv <= !wh;
        end while (!(ah && wh));
        do begin
            @(negedge clk);
            r = br;
        end while (!bv);
        @(posedge clk);
        bry <= 1'b0;
        chk("bresp", e, r);
        repeat (2) @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(negedge clk); while (!arr);
        @(posedge clk);
        arv <= 1'b0;
        do begin
            @(negedge clk);
            d = rdat;
            r = rr;
        end while (!rv);
        @(posedge clk);
        rry <= 1'b0;
        chk("rdata", {24'h0, e}, d);
        chk("rresp", er, r);
    endtask
    // skips one period so a pending change has landed
    task per(input logic [31:0] e);
        @(posedge bclk);
        @(posedge bclk);
        t0 = $time;
        @(posedge bclk);
        chk("period", e, 32'(($time - t0) / 50));
    endtask
    task wake;
        @(posedge clk);
        wk <= 1'b1;
        repeat (4) @(posedge clk);
        wk <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task test_done;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(ADDR_CTL0, CTL0_RST, RESP_OKAY);
        rd(ADDR_CTL1, CTL1_RST, RESP_OKAY);
        rd(ADDR_DIV, DIV_BY8, RESP_OKAY);
        chk("outs", 4'b1101, {mrun, mdrv, sosc, sdrv});
        per(64);
        $display("test reset end");
        foreach (dv[i]) begin
            wr(ADDR_DIV, dv[i], RESP_OKAY);
            rd(ADDR_DIV, dv[i], RESP_OKAY);
            per(32'(dv[i]) * 8);
        end
        wr(ADDR_DIV, 8'h05, RESP_OKAY);
        rd(ADDR_DIV, 8'h10, RESP_OKAY);
        $display("test divider end");
        wr(ADDR_CTL0, 8'h28, RESP_OKAY);
        chk("main_run", 0, mrun);
        rd(ADDR_DIV, DIV_BY8, RESP_OKAY);
        wr(ADDR_DIV, 8'h02, RESP_OKAY);
        rd(ADDR_DIV, DIV_BY8, RESP_OKAY);
        wr(ADDR_CTL0, CTL0_RST, RESP_OKAY);
        chk("main_run", 1, mrun);
        wr(8'h04, 8'hff, RESP_SLVERR);
        rd(8'h04, 8'h00, RESP_SLVERR);
        $display("test halt end");
        wr(ADDR_CTL0, 8'h18, RESP_OKAY);
        chk("sub_osc", 1, sosc);
        repeat (200) @(posedge clk);
        @(posedge s32);
        t0 = $time;
        @(posedge s32);
        chk("div32", 640, 32'(($time - t0) / 50));
        @(posedge sdir);
        t0 = $time;
        @(posedge sdir);
        chk("sub_direct", 20, 32'(($time - t0) / 50));
        wr(ADDR_CTL0, 8'h98, RESP_OKAY);
        do @(posedge clk); while (bsub !== 1'b1);
        per(20);
        $display("test sub end");
        wr(ADDR_CTL0, 8'h90, RESP_OKAY);
        wr(ADDR_CTL1, 8'h00, RESP_OKAY);
        chk("drives", 2'b00, {mdrv, sdrv});
        wr(ADDR_CTL1, 8'h01, RESP_OKAY);
        chk("stop_outs", 4'b0001, {mrun, mdrv, sosc, sdrv});
        rd(ADDR_DIV, DIV_BY8, RESP_OKAY);
        wake;
        rd(ADDR_CTL1, 8'h00, RESP_OKAY);
        wr(ADDR_CTL0, 8'h18, RESP_OKAY);
        do @(posedge clk); while (bsub !== 1'b0);
        wr(ADDR_CTL1, 8'h01, RESP_OKAY);
        chk("main_drv", 1, mdrv);
        wake;
        rd(ADDR_CTL1, CTL1_RST, RESP_OKAY);
        $display("test stop end");
        test_done;
    end
endmodule
